// File: inc/pad_drive_pkg.sv
`default_nettype none
package pad_drive_pkg;

  // Register word indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_BIT_CLOCK = 16'he247;
  localparam logic [15:0] IDX_FRAME_CLOCK = 16'he248;
  localparam logic [15:0] IDX_GENERAL_PIN = 16'he249;
  localparam logic [15:0] IDX_SERIAL_OUT = 16'he24a;
  localparam logic [15:0] IDX_MISC_PAD = 16'he24c;

  // Wishbone geometry.
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 16;

  // Implemented field widths; the bits above read as zero.
  localparam int BIT_CLOCK_W = 12;
  localparam int FRAME_CLOCK_W = 12;
  localparam int GENERAL_PIN_W = 12;
  localparam int SERIAL_OUT_W = 9;
  localparam int MISC_PAD_W = 7;

  // Field masks that keep reserved bits at zero.
  localparam logic [15:0] MASK_BIT_CLOCK = 16'h0fff;
  localparam logic [15:0] MASK_FRAME_CLOCK = 16'h0fff;
  localparam logic [15:0] MASK_GENERAL_PIN = 16'h0fff;
  localparam logic [15:0] MASK_SERIAL_OUT = 16'h01ff;
  localparam logic [15:0] MASK_MISC_PAD = 16'h007f;

  // Every strength register resets to the low drive level.
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // Bit positions inside the miscellaneous register.
  localparam int MISC_MASTER_CLOCK_OUT = 0;
  localparam int MISC_DIGITAL_AUDIO_OUT = 1;
  localparam int MISC_CONTROL_DATA_OUT = 2;
  localparam int MISC_ADDRESS_ZERO = 3;
  localparam int MISC_ADDR1_OR_CONTROL_IN = 4;
  localparam int MISC_CONTROL_LATCH = 5;
  localparam int MISC_CONTROL_SERIAL_CLOCK = 6;

  // Strength encoding for a select bit.
  localparam logic DRIVE_LOW_2MA = 1'b0;
  localparam logic DRIVE_HIGH_6MA = 1'b1;

  // Register selector.
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_BIT_CLOCK = 3'b001,
    SEL_FRAME_CLOCK = 3'b010,
    SEL_GENERAL_PIN = 3'b011,
    SEL_SERIAL_OUT = 3'b100,
    SEL_MISC_PAD = 3'b101
  } reg_sel_t;

  // Wishbone request carried as one group.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  // Strength selects for the miscellaneous pads.
  typedef struct packed {
    logic control_serial_clock_pad;
    logic control_latch_pad;
    logic addr1_or_control_in_pad;
    logic address_zero_pad;
    logic control_data_out_pad;
    logic digital_audio_out_pad;
    logic master_clock_out_pad;
  } misc_drive_t;

endpackage
`default_nettype wire

// File: core/drive_reg16.sv
`timescale 1ns/10ps
`default_nettype none
module drive_reg16
  import pad_drive_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hffff
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Write strobe with byte lanes.
  input wire logic wr_i,
  input wire logic [1:0] be_i,
  input wire logic [15:0] wdata_i,
  // Stored value.
  output logic [15:0] q_o
);
  logic [15:0] q;
  logic [15:0] next_q;

  // Merge the enabled lanes and drop reserved bits so they always read zero.
  always_comb begin
    next_q = q;
    if (wr_i) begin
      if (be_i[0]) begin
        next_q[7:0] = wdata_i[7:0];
      end
      if (be_i[1]) begin
        next_q[15:8] = wdata_i[15:8];
      end
      next_q = next_q & MASK;
    end
  end

  // Reset puts every pad at the low drive level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  rsv_stays_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i) (q & ~MASK) == 16'h0000)
    else $error("reserved strength bits became set");

  write_lands_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && be_i == 2'b11) |=> q == ($past(wdata_i) & MASK))
    else $error("full write did not land in strength register");

  hold_no_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i) !wr_i |=> $stable(q))
    else $error("strength register changed without a write");

  reset_clears_a: assert property (
    @(posedge clk_i) rst_i |=> q == RESET_VALUE)
    else $error("strength register not zero after reset");
endmodule
`default_nettype wire

// File: core/pad_drive_strength_regs.sv
// Function
// - Bit clock register e247 has selects in 11..0, honoured while master; 15..12 reserved.
// - A clear select bit means 2 mA drive and a set one means 6 mA drive.
// - After reset every select bit reads zero so every pad starts at 2 mA.
// - Frame clock register e248 has selects in 11..0, honoured while master; 15..12 reserved.
// - General pin register e249 has selects in 11..0, honoured as an output; 15..12 reserved.
// - Serial output register e24a has selects in bits 8..0; bits 15..9 are reserved.
// - Bits 6..0 of e24c: ctl clock, latch, addr1 or in, address zero, data out, audio, mclk.
// - Software reaches the registers through the control port at their listed addresses.
`timescale 1ns/10ps
`default_nettype none
module pad_drive_strength_regs
  import pad_drive_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [pad_drive_pkg::SEL_W-1:0] sel_i,
  input wire logic [pad_drive_pkg::ADDR_W-1:0] adr_i,
  input wire logic [pad_drive_pkg::DATA_W-1:0] dat_i,
  output logic [pad_drive_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Pad mode qualifiers from the serial ports and pin muxes.
  input wire logic [pad_drive_pkg::BIT_CLOCK_W-1:0] bit_clock_master_i,
  input wire logic [pad_drive_pkg::FRAME_CLOCK_W-1:0] frame_clock_master_i,
  input wire logic [pad_drive_pkg::GENERAL_PIN_W-1:0] general_pin_output_i,
  // Strength selects to the pads, high means 6 mA.
  output logic [pad_drive_pkg::BIT_CLOCK_W-1:0] bit_clock_pad_n_o,
  output logic [pad_drive_pkg::FRAME_CLOCK_W-1:0] frame_clock_pad_n_o,
  output logic [pad_drive_pkg::GENERAL_PIN_W-1:0] general_pin_pad_n_o,
  output logic [pad_drive_pkg::SERIAL_OUT_W-1:0] serial_out_pad_n_o,
  output pad_drive_pkg::misc_drive_t misc_pad_o
);
  import pad_drive_pkg::*;

  localparam int NREG = 5;
  localparam logic [15:0] MASKS [NREG] = '{MASK_BIT_CLOCK, MASK_FRAME_CLOCK,
    MASK_GENERAL_PIN, MASK_SERIAL_OUT, MASK_MISC_PAD};

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Turn a bus byte address into a register selector; unmapped gives none.
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] adr);
    logic [15:0] idx;
    idx = adr[ADDR_W-1:2];
    case (idx)
      IDX_BIT_CLOCK: decode = SEL_BIT_CLOCK;
      IDX_FRAME_CLOCK: decode = SEL_FRAME_CLOCK;
      IDX_GENERAL_PIN: decode = SEL_GENERAL_PIN;
      IDX_SERIAL_OUT: decode = SEL_SERIAL_OUT;
      IDX_MISC_PAD: decode = SEL_MISC_PAD;
      default: decode = SEL_NONE;
    endcase
  endfunction

  wb_req_t req;
  reg_sel_t hit;
  logic req_live;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
  assign hit = decode(req.adr);
  // A new request is live only while no answer is out, so each takes one answer.
  assign req_live = req.cyc && req.stb && !ack_o && !err_o;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [15:0] regs [NREG];

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      drive_reg16 #(
        .MASK(MASKS[g])
      ) u_reg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(req_live && req.we && hit == reg_sel_t'(g + 1)),
        .be_i(req.sel[1:0]),
        .wdata_i(req.dat[15:0]),
        .q_o(regs[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack for mapped words, err for unmapped, one cycle after taking.

  logic ack;
  logic err;
  logic [DATA_W-1:0] rdata;
  logic next_ack;
  logic next_err;
  logic [DATA_W-1:0] next_rdata;

  // Read data is registered; reserved and upper bits come back as zero.
  always_comb begin
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = rdata;
    if (req_live) begin
      if (hit == SEL_NONE) begin
        next_err = 1'b1;
        next_rdata = '0;
      end else begin
        next_ack = 1'b1;
        next_rdata = {16'h0000, regs[int'(hit) - 1]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  assign ack_o = ack;
  assign err_o = err;
  assign dat_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Pad selects. A bit clock, frame clock or general pin pad only honours its
  // select while it drives; as an input the pad keeps its low-drive default.

  always_comb begin
    bit_clock_pad_n_o = regs[0][BIT_CLOCK_W-1:0] & bit_clock_master_i;
    frame_clock_pad_n_o = regs[1][FRAME_CLOCK_W-1:0] & frame_clock_master_i;
    general_pin_pad_n_o = regs[2][GENERAL_PIN_W-1:0] & general_pin_output_i;
    serial_out_pad_n_o = regs[3][SERIAL_OUT_W-1:0];
    misc_pad_o = misc_drive_t'(regs[4][MISC_PAD_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // A taken request is answered once, and the answer falls again at once.
  sequence s_take;
    req_live;
  endsequence

  sequence s_answer;
    ##1 (ack_o ^ err_o) ##1 (!ack_o && !err_o);
  endsequence

  bus_one_ack_a: assert property (
    @(posedge clk_i) disable iff (rst_i) s_take |-> s_answer)
    else $error("bus answer was not a single cycle pulse");

  // Unmapped words are refused rather than silently acknowledged.
  unmapped_err_a: assert property (
    @(posedge clk_i) disable iff (rst_i) (req_live && hit == SEL_NONE) |=> err_o)
    else $error("unmapped access did not raise err");

  misc_master_clock_out_pad_map_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    misc_pad_o.master_clock_out_pad == regs[4][MISC_MASTER_CLOCK_OUT]
    && misc_pad_o.control_serial_clock_pad == regs[4][MISC_CONTROL_SERIAL_CLOCK])
    else $error("miscellaneous pad mapping wrong");

  slave_pad_low_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bit_clock_pad_n_o & ~bit_clock_master_i) == '0)
    else $error("bit clock pad raised while not master");

  serial_read_back_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_live && !req.we && hit == SEL_SERIAL_OUT) |=> dat_o == {16'h0000, regs[3]}
    && dat_o[DATA_W-1:SERIAL_OUT_W] == '0)
    else $error("serial output register read back wrong");

  reset_low_drive_a: assert property (
    @(posedge clk_i) rst_i |=> serial_out_pad_n_o == '0 && misc_pad_o == '0)
    else $error("pads not at low drive after reset");

  // Reads never show anything above the sixteen register bits.
  read_upper_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i) ack_o |-> dat_o[DATA_W-1:REG_W] == '0)
    else $error("read data above the register width was not zero");

  // An error answer carries no data, so stale read data is never taken as a value.
  err_data_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i) err_o |-> dat_o == '0)
    else $error("error answer carried data");

  // Both answers at once would let a master take a refused access as good.
  answer_exclusive_a: assert property (
    @(posedge clk_i) disable iff (rst_i) !(ack_o && err_o))
    else $error("ack and err raised together");

  // A refused write must leave every strength register as it was.
  refused_no_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_live && req.we && hit == SEL_NONE) |=> $stable(regs[0]) && $stable(regs[1])
    && $stable(regs[2]) && $stable(regs[3]) && $stable(regs[4]))
    else $error("unmapped write changed a strength register");

  // A full serial output write reaches its pads in the cycle after it is taken.
  serial_pad_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_live && req.we && hit == SEL_SERIAL_OUT && req.sel[1:0] == 2'b11)
    |=> serial_out_pad_n_o == $past(req.dat[SERIAL_OUT_W-1:0]))
    else $error("serial output pad select did not follow the write");

  // The low byte of a miscellaneous write lands field for field on the named pads.
  sequence s_misc_write;
    req_live && req.we && hit == SEL_MISC_PAD && req.sel[0];
  endsequence

  misc_pad_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_misc_write |=> misc_pad_o == misc_drive_t'($past(req.dat[MISC_PAD_W-1:0])))
    else $error("miscellaneous pad selects did not follow the write");
endmodule
`default_nettype wire

// File: tb/test_pad_drive_strength_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_pad_drive_strength_regs;
  import pad_drive_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, err, e;
  logic [SEL_W-1:0] sel;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wdat, rdat, q, wd;
  logic [11:0] bcm, fcm, gpo, bco, fco, gpp;
  logic [8:0] sdo;
  logic [15:0] v;
  misc_drive_t misc_pads;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 9055;
  int cycles = 0;
  logic [15:0] idx [5] = '{IDX_BIT_CLOCK, IDX_FRAME_CLOCK, IDX_GENERAL_PIN,
    IDX_SERIAL_OUT, IDX_MISC_PAD};
  logic [15:0] msk [5] = '{MASK_BIT_CLOCK, MASK_FRAME_CLOCK, MASK_GENERAL_PIN,
    MASK_SERIAL_OUT, MASK_MISC_PAD};
  logic [15:0] bad [3] = '{16'he246, 16'he24b, 16'he24d};

  pad_drive_strength_regs i_pad_drive_strength_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .err_o(err), .bit_clock_master_i(bcm), .frame_clock_master_i(fcm),
    .general_pin_output_i(gpo), .bit_clock_pad_n_o(bco),
    .frame_clock_pad_n_o(fco), .general_pin_pad_n_o(gpp),
    .serial_out_pad_n_o(sdo), .misc_pad_o(misc_pads)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // A hung handshake must still end in the verdict.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles >= 3000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      n_errors = n_errors + 1;
    end
  endtask

  // One classic cycle; entered just after an edge, holds until ack or err.
  task automatic bus(input logic w, input logic [15:0] i, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r, output logic o);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {i, 2'b00};
    wdat <= d;
    // Waits as long as the slave needs; only the cycle ceiling ends a hang.
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    r = rdat;
    o = err;
    chk({31'h0, ack ^ err}, 32'h1, "one answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  // Pad selects of register k, and the qualifier that gates them.
  function automatic logic [15:0] pads(input int k);
    case (k)
      0: return {4'h0, bco};
      1: return {4'h0, fco};
      2: return {4'h0, gpp};
      3: return {7'h00, sdo};
      default: return {9'h000, misc_pads};
    endcase
  endfunction

  function automatic logic [15:0] gate(input int k);
    case (k)
      0: return {4'h0, bcm};
      1: return {4'h0, fcm};
      2: return {4'h0, gpo};
      default: return 16'hffff;
    endcase
  endfunction

  // Picks a miscellaneous pad by its field name, not by position.
  function automatic logic misc_bit(input int b);
    case (b)
      0: return misc_pads.master_clock_out_pad;
      1: return misc_pads.digital_audio_out_pad;
      2: return misc_pads.control_data_out_pad;
      3: return misc_pads.address_zero_pad;
      4: return misc_pads.addr1_or_control_in_pad;
      5: return misc_pads.control_latch_pad;
      default: return misc_pads.control_serial_clock_pad;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, random traffic, byte lanes, field map, errors.
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, sel, adr, wdat} = '0;
    // Qualifiers start high so the reset check sees every pad ungated.
    {bcm, fcm, gpo} = '1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, idx[k], 4'hf, 32'h0, q, e);
      chk(q, 32'h0, "reset read");
      chk(pads(k), 16'h0, "reset pad");
    end
    $display("test reset_values done");
    // First pass writes all ones with every pad qualified, then random.
    for (int it = 0; it < 8; it++) begin
      for (int k = 0; k < 5; k++) begin
        wd = (it == 0) ? 32'hffffffff : $random(seed);
        v = wd[15:0];
        bcm <= (it == 0) ? 12'hfff : 12'($random(seed));
        fcm <= (it == 0) ? 12'hfff : 12'($random(seed));
        gpo <= (it == 0) ? 12'hfff : 12'($random(seed));
        bus(1'b1, idx[k], 4'hf, wd, q, e);
        chk(pads(k), v & msk[k] & gate(k), "pad select");
        bus(1'b0, idx[k], 4'hf, 32'h0, q, e);
        chk(q, {16'h0, v & msk[k]}, "read back");
        chk({31'h0, e}, 32'h0, "read answer");
      end
    end
    $display("test random_rw done");
    bus(1'b1, IDX_SERIAL_OUT, 4'hf, 32'h0000ffff, q, e);
    bus(1'b1, IDX_SERIAL_OUT, 4'h1, 32'h0, q, e);
    bus(1'b1, IDX_SERIAL_OUT, 4'hc, 32'hffffffff, q, e);
    bus(1'b0, IDX_SERIAL_OUT, 4'hf, 32'h0, q, e);
    chk(q, 32'h00000100, "byte lane");
    $display("test byte_lanes done");
    for (int b = 0; b < 7; b++) begin
      bus(1'b1, IDX_MISC_PAD, 4'hf, 32'h1 << b, q, e);
      chk(pads(4), 16'h1 << b, "misc map");
      chk(misc_bit(b), 1'b1, "misc field");
    end
    $display("test misc_map done");
    for (int j = 0; j < 3; j++) begin
      bus(1'b1, bad[j], 4'hf, 32'hffffffff, q, e);
      chk(e, 1'b1, "unmapped write");
      bus(1'b0, bad[j], 4'hf, 32'h0, q, e);
      chk(q, 32'h0, "unmapped read");
      chk({31'h0, e}, 32'h1, "unmapped read err");
    end
    // The miscellaneous register between the refused words e24b and e24d must still hold what it had.
    bus(1'b0, IDX_MISC_PAD, 4'hf, 32'h0, q, e);
    chk(q, 32'h1 << MISC_CONTROL_SERIAL_CLOCK, "refused write kept");
    $display("test unmapped done");
    // Software hands every pad back at the low level once its test is over.
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, idx[k], 4'hf, 32'h0, q, e);
      chk(pads(k), 16'h0, "low drive restore");
    end
    $display("test low_restore done");
    // Leave one register high so the second reset has something to clear.
    bus(1'b1, IDX_MISC_PAD, 4'hf, 32'hffffffff, q, e);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, idx[k], 4'hf, 32'h0, q, e);
      chk(q, 32'h0, "second reset");
    end
    $display("test mid_reset done");
    close_out();
  end
endmodule
`default_nettype wire
